// [rtl/adp_cfg.svh]
// Purpose: Constants for the converter port and result register bank
// Assumes: Byte-indexed offsets, byte address is four times the index
// Notes: Included by bare name
`ifndef ADP_CFG_SVH
`define ADP_CFG_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define ADP_IDX_ENABLE_HIGH 8'h0C
`define ADP_IDX_ENABLE_LOW 8'h0D
`define ADP_IDX_LEVEL_HIGH 8'h0E
`define ADP_IDX_LEVEL_LOW 8'h0F
`define ADP_IDX_TRIGGER_CFG 8'h01
`define ADP_IDX_CONV_CTL5 8'h05
`define ADP_IDX_MODE 8'h06
`define ADP_IDX_RESULT_BASE 8'h10
`define ADP_IDX_RESULT_LAST 8'h1F

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define ADP_TRIG_CH_LSB 0
`define ADP_TRIG_SEL_BIT 5
`define ADP_TRIG_EN_BIT 7
`define ADP_CTL5_SIGNED_BIT 6
`define ADP_CTL5_JUSTIFY_BIT 7
`define ADP_MODE_SPECIAL_BIT 0
`define ADP_TRIG_CFG_RESET 8'h0F
`define ADP_ENABLE_RESET 8'h00
`define ADP_CTL5_RESET 8'h00
`define ADP_LEVEL_RESET 16'hFFFF
`define ADP_RESULT_BITS 10
`define ADP_CHANNELS 16

`endif

// [rtl/adp_pkg.sv]
// Purpose: Types for the converter port and result register bank
// Assumes: Nothing beyond the header
// Notes: Carriers only
package adp_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } adp_wbreq_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } adp_wbrsp_s;

  typedef struct packed {
    logic valid;
    logic [3:0] slot;
    logic [9:0] value;
  } adp_conv_s;
endpackage

// [rtl/adp_result_mem.sv]
// Purpose: Sixteen-entry result store with registered read data
// Assumes: One write port, one read port, same clock
// Notes: Read data lags the address by one cycle
`timescale 1ns/1ps
module adp_result_mem #(
  parameter int Depth = 16,
  parameter int Width = 16,
  parameter int AddrW = 4
) (
  input wire logic core_clk,
  input wire logic clkEn,
  input wire logic wrEn,
  input wire logic [AddrW-1:0] wrAddr,
  input wire logic [Width-1:0] wrData,
  input wire logic [AddrW-1:0] rdAddr,
  output logic [Width-1:0] rdData_q
);
  logic [Width-1:0] store [Depth];

  always_ff @(posedge core_clk) begin
    if (clkEn && wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      rdData_q <= store[rdAddr];
    end
  end
endmodule

// [rtl/adp_port_results.sv]
// Purpose: Digital input enables, pin level ports and conversion results
// Assumes: Classic Wishbone slave, byte index times four is the address
// Notes: Sequencer and analog machine live elsewhere and feed convIn
`timescale 1ns/1ps
`include "adp_cfg.svh"
module adp_port_results #(
  parameter int Channels = `ADP_CHANNELS,
  parameter int ResultBits = `ADP_RESULT_BITS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire adp_pkg::adp_wbreq_s wbReq,
  output adp_pkg::adp_wbrsp_s wbRsp,
  input wire adp_pkg::adp_conv_s convIn,
  input wire logic [15:0] analogInputPin,
  output logic [15:0] inputBufferEnableBit
);
  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic [7:0] regIdx;
  logic busReq;
  logic ack_q;
  logic wrStrobe;
  logic laneLow;
  logic [31:0] rdData_q;
  logic busTake;
  logic regWrite;
  logic hitEnableHigh;
  logic hitEnableLow;
  logic hitTrigger;
  logic hitCtl5;
  logic hitMode;
  logic hitResult;

  function automatic logic isResult(input logic [7:0] idx);
    isResult = (idx >= `ADP_IDX_RESULT_BASE) && (idx <= `ADP_IDX_RESULT_LAST);
  endfunction

  // One compare shape for every single-index register keeps the decode on the same index bits
  function automatic logic hitIndex(input logic [7:0] idx, input logic [7:0] target);
    hitIndex = (idx == target);
  endfunction

  assign regIdx = wbReq.adr[9:2];
  assign busReq = wbReq.cyc && wbReq.stb;
  // Single wait state, ack drops the cycle after it was given
  assign busTake = busReq && !ack_q;
  assign wrStrobe = busTake && wbReq.we && clkEn;
  assign laneLow = wbReq.sel[0];
  // Register bytes ride on lane zero only
  assign regWrite = wrStrobe && laneLow;

  assign hitEnableHigh = hitIndex(regIdx, `ADP_IDX_ENABLE_HIGH);
  assign hitEnableLow = hitIndex(regIdx, `ADP_IDX_ENABLE_LOW);
  assign hitTrigger = hitIndex(regIdx, `ADP_IDX_TRIGGER_CFG);
  assign hitCtl5 = hitIndex(regIdx, `ADP_IDX_CONV_CTL5);
  assign hitMode = hitIndex(regIdx, `ADP_IDX_MODE);
  assign hitResult = isResult(regIdx);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else if (clkEn) begin
      ack_q <= busTake;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] enableHigh_q;
  logic [7:0] enableLow_q;
  logic [7:0] triggerCfg_q;
  logic [7:0] convCtl5_q;
  logic specialMode_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      enableHigh_q <= `ADP_ENABLE_RESET;
    end else if (regWrite && hitEnableHigh) begin
      enableHigh_q <= wbReq.dat[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      enableLow_q <= `ADP_ENABLE_RESET;
    end else if (regWrite && hitEnableLow) begin
      enableLow_q <= wbReq.dat[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      triggerCfg_q <= `ADP_TRIG_CFG_RESET;
    end else if (regWrite && hitTrigger) begin
      triggerCfg_q <= wbReq.dat[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      convCtl5_q <= `ADP_CTL5_RESET;
    end else if (regWrite && hitCtl5) begin
      convCtl5_q <= wbReq.dat[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      specialMode_q <= 1'b0;
    end else if (regWrite && hitMode) begin
      specialMode_q <= wbReq.dat[`ADP_MODE_SPECIAL_BIT];
    end
  end

  // Enable bits go out to the pads to switch the buffers
  assign inputBufferEnableBit = {enableHigh_q, enableLow_q};

  // ----------------------------------------
  // Pin level port
  // ----------------------------------------
  logic [15:0] pinMeta_q;
  logic [15:0] pinSync_q;
  logic [15:0] pinLevel_q;
  logic trigEnable;
  logic trigFromPin;
  logic [3:0] trigChannel;
  wire logic [15:0] trigMatch;
  wire logic [15:0] passMask;

  assign trigEnable = triggerCfg_q[`ADP_TRIG_EN_BIT];
  assign trigFromPin = !triggerCfg_q[`ADP_TRIG_SEL_BIT];
  assign trigChannel = triggerCfg_q[`ADP_TRIG_CH_LSB +: 4];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinMeta_q <= `ADP_LEVEL_RESET;
      pinSync_q <= `ADP_LEVEL_RESET;
    end else if (clkEn) begin
      pinMeta_q <= analogInputPin;
      pinSync_q <= pinMeta_q;
    end
  end

  // Disabled buffers read as one unless the pin trigger selects that channel, whose level then passes
  genvar ch;
  generate
    for (ch = 0; ch < Channels; ch++) begin : gPin
      assign trigMatch[ch] = trigEnable && trigFromPin && (trigChannel == 4'(ch));
      assign passMask[ch] = inputBufferEnableBit[ch] || trigMatch[ch];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinLevel_q <= `ADP_LEVEL_RESET;
    end else if (clkEn) begin
      pinLevel_q <= (pinSync_q & passMask) | ~passMask;
    end
  end

  // ----------------------------------------
  // Result formatting and store
  // ----------------------------------------
  logic justifyLeft;
  logic signedReq;
  logic [15:0] formatted;
  logic [ResultBits-1:0] rawValue;
  logic memWrEn;
  logic [3:0] memWrAddr;
  logic [15:0] memWrData;
  logic [15:0] memRdData;
  logic swResultWr;

  assign justifyLeft = convCtl5_q[`ADP_CTL5_JUSTIFY_BIT];
  assign signedReq = convCtl5_q[`ADP_CTL5_SIGNED_BIT];
  assign rawValue = convIn.value[ResultBits-1:0];

  always_comb begin
    formatted = 16'h0000;
    case ({justifyLeft, signedReq})
      2'b11: begin
        // Offset binary to two's complement is a flip of the top bit
        formatted[15 -: ResultBits] = {~rawValue[ResultBits-1], rawValue[ResultBits-2:0]};
      end
      2'b10: begin
        formatted[15 -: ResultBits] = rawValue;
      end
      default: begin
        // Right justification ignores the signed request
        formatted[ResultBits-1:0] = rawValue;
      end
    endcase
  end

  // Software write in special mode only
  assign swResultWr = wrStrobe && hitResult && specialMode_q;

  // The converter takes the port; a software write in that same cycle is lost
  always_comb begin
    memWrEn = 1'b0;
    memWrAddr = regIdx[3:0];
    memWrData = wbReq.dat[15:0];
    if (convIn.valid) begin
      memWrEn = 1'b1;
      memWrAddr = convIn.slot;
      memWrData = formatted;
    end else if (swResultWr) begin
      memWrEn = 1'b1;
    end
  end

  adp_result_mem #(
    .Depth(16),
    .Width(16),
    .AddrW(4)
  ) uResultMem (
    .core_clk(core_clk),
    .clkEn(clkEn),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddr(regIdx[3:0]),
    .rdData_q(memRdData)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [7:0] readByte;

  // Level ports have no write path at all, so a write there only acks
  always_comb begin
    readByte = 8'h00;
    case (regIdx)
      `ADP_IDX_ENABLE_HIGH: begin
        readByte = enableHigh_q;
      end
      `ADP_IDX_ENABLE_LOW: begin
        readByte = enableLow_q;
      end
      `ADP_IDX_LEVEL_HIGH: begin
        readByte = pinLevel_q[15:8];
      end
      `ADP_IDX_LEVEL_LOW: begin
        readByte = pinLevel_q[7:0];
      end
      `ADP_IDX_TRIGGER_CFG: begin
        readByte = triggerCfg_q;
      end
      `ADP_IDX_CONV_CTL5: begin
        readByte = convCtl5_q;
      end
      `ADP_IDX_MODE: begin
        readByte = {7'h00, specialMode_q};
      end
      default: begin
        readByte = 8'h00;
      end
    endcase
  end

  // Result data arrive from the memory register in the ack cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_q <= 32'h0000_0000;
    end else if (clkEn) begin
      rdData_q <= {24'h00_0000, readByte};
    end
  end

  always_comb begin
    wbRsp.ack = ack_q;
    if (hitResult) begin
      wbRsp.dat = {16'h0000, memRdData};
    end else begin
      wbRsp.dat = rdData_q;
    end
  end
endmodule

// [tb/adp_port_results_sva.sv]
// Purpose: Bus and port checks on adp_port_results
// Assumes: clkEn high while a request is up, trigger never on channels 7-0
// Notes: Bound from the bench top
`timescale 1ns/1ps
module adp_port_results_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire adp_pkg::adp_wbreq_s wbReq,
  input wire adp_pkg::adp_wbrsp_s wbRsp,
  input wire logic [15:0] inputBufferEnableBit
);
  // ----
  // Checks
  // ----
  logic tk;
  logic ra;
  logic [7:0] ix;
  assign ix = wbReq.adr[9:2];
  assign tk = wbReq.cyc && wbReq.stb && !wbRsp.ack;
  assign ra = wbRsp.ack && !wbReq.we;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_one; wbRsp.ack |=> !wbRsp.ack; endproperty
  a_one: assert property (p_one) else $error("ack too long");
  property p_ans; tk |=> wbRsp.ack; endproperty
  a_ans: assert property (p_ans) else $error("no ack");
  property p_rst; $fell(rst) |-> inputBufferEnableBit == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("enable reset");
  property p_wen; tk && wbReq.we && wbReq.sel[0] && ix == 8'h0C
    |=> inputBufferEnableBit[15:8] == $past(wbReq.dat[7:0]); endproperty
  a_wen: assert property (p_wen) else $error("enable write");
  property p_ren; ra && ix == 8'h0D |-> wbRsp.dat == {24'h00_0000, inputBufferEnableBit[7:0]}; endproperty
  a_ren: assert property (p_ren) else $error("enable read");
  property p_lwr; tk && wbReq.we && ix[7:1] == 7'h07 |=> $stable(inputBufferEnableBit); endproperty
  a_lwr: assert property (p_lwr) else $error("port write");
  property p_ones; ra && ix == 8'h0F |-> (wbRsp.dat[7:0] | inputBufferEnableBit[7:0]) == 8'hFF; endproperty
  a_ones: assert property (p_ones) else $error("port ones");
  property p_res; ra && ix[7:4] == 4'h1 |-> wbRsp.dat[31:16] == 16'h0000; endproperty
  a_res: assert property (p_res) else $error("result width");
  c_a: cover property (ra && ix == 8'h0F);
  c_b: cover property (tk && wbReq.we && ix[7:4] == 4'h1);
  c_c: cover property (ra && ix == 8'h0E);
endmodule

// [tb/adp_pin_model.sv]
// Purpose: Pin levels seen by the port block
// Assumes: No pulls on the pins
// Notes: Channel 13 carries an analog swing
`timescale 1ns/1ps
module adp_pin_model (
  input wire logic core_clk,
  input wire logic [15:0] want,
  output logic [15:0] analogInputPin
);
  // ----
  // Drive
  // ----
  logic sw_q = 1'b0;
  // Buffer on 13 stays off, else the swing burns current
  always @(posedge core_clk) begin
    sw_q <= !sw_q;
    analogInputPin <= want ^ {2'b00, sw_q, 13'h0000};
  end
endmodule

// [tb/test_adp_port_results.sv]
// Purpose: Bench for adp_port_results
// Assumes: clkEn high except in t_freeze, one wait state per access
// Notes: Pins come from adp_pin_model
`timescale 1ns/1ps
module test_adp_port_results;
  // ----
  // Harness
  // ----
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  adp_pkg::adp_wbreq_s rq = '0;
  adp_pkg::adp_wbrsp_s rs;
  adp_pkg::adp_conv_s cv = '0;
  logic [15:0] want = 16'h0000;
  logic [15:0] pin;
  logic [15:0] ie;
  int bad_count = 0;
  int checks = 0;
  adp_port_results dut (.core_clk(core_clk), .rst(rst), .clkEn(ce), .wbReq(rq), .wbRsp(rs),
    .convIn(cv), .analogInputPin(pin), .inputBufferEnableBit(ie));
  adp_pin_model pm (.core_clk(core_clk), .want(want), .analogInputPin(pin));
  initial begin
    forever #5 core_clk = !core_clk;
  end
  task automatic conclude();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Waits for ack as long as it takes; the watchdog ends a dead wait
  task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk);
    rq <= '{1'b1, 1'b1, w, 4'h1, {22'h00_0000, ix, 2'b00}, wd};
    do begin
      @(posedge core_clk);
    end while (rs.ack !== 1'b1);
    rd = rs.dat;
    rq <= '0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ix, d, x);
  endtask
  task automatic rd(input logic [7:0] ix, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, ix, 32'h0000_0000, x);
    chk($sformatf("reg %h", ix), x, e);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    rd(8'h0E, 32'h0000_00FF);
    rd(8'h0F, 32'h0000_00FF);
    rd(8'h01, 32'h0000_000F);
    chk("enables", {16'h0000, ie}, 32'h0000_0000);
  endtask
  task automatic t_port();
    wr(8'h0C, 32'h0000_0085);
    wr(8'h0D, 32'h0000_003C);
    want <= 16'h5A0F;
    repeat (6) @(posedge core_clk);
    chk("enables", {16'h0000, ie}, 32'h0000_853C);
    rd(8'h0C, 32'h0000_0085);
    wr(8'h0E, 32'h0000_0000);
    rd(8'h0E, {24'h00_0000, (want[15:8] & 8'h85) | ~8'h85});
    rd(8'h0F, {24'h00_0000, (want[7:0] & 8'h3C) | ~8'h3C});
    wr(8'h0D, 32'h0000_0000);
    rd(8'h0F, 32'h0000_00FF);
  endtask
  task automatic t_trig();
    wr(8'h0C, 32'h0000_0000);
    want <= 16'h4A0F;
    wr(8'h01, 32'h0000_008C);
    repeat (6) @(posedge core_clk);
    rd(8'h0E, 32'h0000_00EF);
    wr(8'h01, 32'h0000_00AC);
    rd(8'h0E, 32'h0000_00FF);
  endtask
  task automatic t_res();
    logic [7:0] m [4];
    logic [9:0] v;
    m = '{8'h00, 8'h80, 8'hC0, 8'h40};
    v = 10'h2C5;
    for (int i = 0; i < 4; i++) begin
      wr(8'h05, {24'h00_0000, m[i]});
      @(posedge core_clk);
      cv <= '{1'b1, 4'(i), v};
      @(posedge core_clk);
      cv <= '0;
      rd(8'h10 + 8'(i), m[i][7] ? {16'h0000, v ^ {m[i][6], 9'h000}, 6'h00} : {22'h00_0000, v});
    end
    wr(8'h13, 32'h0000_1234);
    rd(8'h13, 32'h0000_02C5);
    wr(8'h06, 32'h0000_0001);
    wr(8'h13, 32'h0000_1234);
    rd(8'h13, 32'h0000_1234);
    rd(8'h30, 32'h0000_0000);
  endtask
  // A low enable freezes the result store even with a strobe up
  task automatic t_freeze();
    ce <= 1'b0;
    cv <= '{1'b1, 4'h0, 10'h155};
    repeat (2) @(posedge core_clk);
    cv <= '0;
    ce <= 1'b1;
    rd(8'h10, 32'h0000_02C5);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_port();
    t_trig();
    t_res();
    t_freeze();
    conclude();
  end
  initial begin
    #100000;
    bad_count++;
    conclude();
  end
endmodule
bind adp_port_results adp_port_results_sva chk_i (.core_clk(core_clk), .rst(rst), .wbReq(wbReq),
  .wbRsp(wbRsp), .inputBufferEnableBit(inputBufferEnableBit));
